// [rtl/twowire_pkg.sv]
// constants shared by both ends of the charger register link
// assumes both ends run on one 100 MHz system clock
package twowire_pkg;
    localparam logic [6:0] TARGET_ADDR      = 7'h3B;
    localparam int         REG_COUNT        = 16;
    localparam logic [7:0] LAST_REG         = 8'h0F;
    localparam logic [7:0] BEYOND_READ      = 8'hFF;
    localparam logic [7:0] FIRST_CTRL_OFF   = 8'h00;
    localparam logic [7:0] POWER_ON_VALUE   = 8'h17;
    localparam int         DISCONNECT_BIT   = 7;
    localparam int         STATUS_FN_HI     = 6;
    localparam int         STATUS_FN_LO     = 5;
    localparam int         LIMIT_HI         = 4;
    localparam logic [1:0] STATUS_FN_CHARGE = 2'h0;
    localparam logic [1:0] STATUS_FN_CUSTOM = 2'h1;
    localparam logic [4:0] LIMIT_TOP_CODE   = 5'h1F;
    localparam logic [3:0] BIT_LAST         = 4'h7;
    localparam logic [3:0] BIT_ACK          = 4'h8;
    // controller command register map
    localparam logic [1:0] CMD_ADDR_REG     = 2'h0;
    localparam logic [1:0] CMD_ADDR_DATA    = 2'h1;
    localparam logic [1:0] CMD_ADDR_GO      = 2'h2;
    localparam logic [1:0] CMD_ADDR_STATUS  = 2'h3;
    localparam int         GO_READ_BIT      = 0;
    localparam int         GO_COUNT_LO      = 4;
    // link clock quarter step in system clocks (four steps make a 160 ns period at 10 ns)
    localparam int         HALF_PERIOD_NS   = 40;
    localparam int         CLK_PERIOD_NS    = 10;
    localparam int         HALF_CYCLES      = HALF_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [7:0] HALF_CNT         = 8'(HALF_CYCLES - 1);
endpackage : twowire_pkg

// [rtl/twowire_if.sv]
// two-wire bus carrier joining the controller and target ends
// open-drain: a party pulls low when its enable is low; wire-and with pull-up
`timescale 1ns/1ps
interface twowire_if;
    logic scl_o_n_en_ctl;
    logic sda_oe_n_ctl;
    logic sda_oe_n_tgt;
    logic scl_line;
    logic sda_line;
    assign scl_line = scl_o_n_en_ctl;
    assign sda_line = sda_oe_n_ctl & sda_oe_n_tgt;
    modport controller (output scl_o_n_en_ctl, output sda_oe_n_ctl,
                        input scl_line, input sda_line);
    modport target     (output sda_oe_n_tgt, input scl_line, input sda_line);
endinterface : twowire_if

// [rtl/sync2.sv]
// two-flop synchroniser for a pin level
// assumes the input is asynchronous to CLK
`timescale 1ns/1ps
module sync2 (
    input  wire logic CLK,    // system clock
    input  wire logic RST,    // synchronous reset, high
    input  wire logic d,      // asynchronous level
    output logic      q       // synchronised level
);
    logic meta_reg;
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            meta_reg <= 1'b1;
            q        <= 1'b1;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : sync2

// [rtl/charger_target.sv]
// target end: two-wire register port of the charger with sixteen registers
// assumes the controller makes the link clock; both wires sampled by CLK
//
// Summary of operation
// - data falls while clock high: start
// - data rises while clock high: stop
// - bus busy from start until stop
// - data changes only while clock low
// - eight bits per byte, MSB first
// - ninth clock carries receiver acknowledge
// - controller makes every clock pulse
// - first byte: address plus direction bit
// - answer only target address 0x3B
// - direction fixed until repeated start
// - first written byte loads register pointer
// - write data stored, pointer then advances
// - read: pointer write, repeated start, read
// - read sends register, acknowledge advances pointer
// - controller ends transaction with stop
// - registers eight bits, bit 7 MSB
// - bit 7 enables input disconnect mode
// - bits 6:5 select status pin function
// - bits 4:0 input current limit code
// - limit powers up 10111, detection updates
// - sixteen registers; beyond 0x0F reads 0xFF
//
// The two-wire register port was chosen for this implementation.
`timescale 1ns/1ps
module charger_target (
    input  wire logic       CLK,                    // system clock
    input  wire logic       RST,                    // synchronous reset, high
    twowire_if.target       BUS,                    // two-wire link
    input  wire logic       REG_RESET,              // register reset pulse
    input  wire logic       WATCHDOG_EXPIRED,       // watchdog expiry pulse
    input  wire logic       DETECT_DONE,            // input source detection done pulse
    input  wire logic [4:0] DETECT_LIMIT,           // limit found by detection
    input  wire logic       CHARGING,               // charging state for status pin
    input  wire logic       CUSTOM_STATUS,          // custom status bit for status pin
    output logic            INPUT_DISCONNECT_MODE,  // input isolated from circuits
    output logic [4:0]      INPUT_CURRENT_LIMIT,    // current limit code
    output logic            STATUS_PIN_OE_N,        // status pin pulls low when low
    output logic            BUS_BUSY                // start seen, no stop yet
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_PTR  = 3'b010,
        ST_WDAT = 3'b011,
        ST_RDAT = 3'b100,
        ST_SKIP = 3'b101
    } tstate_t;

    logic       scl_s;
    logic       sda_s;
    logic       scl_d_reg;
    logic       sda_d_reg;
    tstate_t    state_reg;
    logic [3:0] bit_reg;
    logic [7:0] shift_reg;
    logic [7:0] ptr_reg;
    logic [7:0] tx_reg;
    logic       detect_seen_reg;
    logic       rd_ack_ok_reg;
    logic       rd_first_reg;
    logic [7:0] regs [twowire_pkg::REG_COUNT];

    sync2 u_sync_scl (.CLK(CLK), .RST(RST), .d(BUS.scl_line), .q(scl_s));
    sync2 u_sync_sda (.CLK(CLK), .RST(RST), .d(BUS.sda_line), .q(sda_s));

    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic in_range;
    logic [7:0] rd_value;
    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    assign in_range = (ptr_reg <= twowire_pkg::LAST_REG);
    assign rd_value = in_range ? regs[ptr_reg[3:0]] : twowire_pkg::BEYOND_READ;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            BUS_BUSY <= 1'b0;
        else if (start_ev)
            BUS_BUSY <= 1'b1;
        else if (stop_ev)
            BUS_BUSY <= 1'b0;
    end

    // byte engine: bits 0..7 shift MSB first, bit 8 is the acknowledge slot
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state_reg     <= ST_IDLE;
            bit_reg       <= 4'h0;
            shift_reg     <= 8'h00;
            ptr_reg       <= 8'h00;
            tx_reg        <= 8'h00;
            rd_ack_ok_reg <= 1'b0;
            rd_first_reg  <= 1'b0;
        end
        else if (start_ev)
        begin
            state_reg    <= ST_ADDR;
            rd_first_reg <= 1'b0;
            // the clock fall that follows a start is not a bit boundary
            bit_reg      <= '1;
        end
        else if (stop_ev)
            state_reg <= ST_IDLE;
        else if (scl_rise && state_reg != ST_IDLE)
        begin
            if (bit_reg < twowire_pkg::BIT_ACK)
                shift_reg <= {shift_reg[6:0], sda_s};
            else if (state_reg == ST_RDAT)
                rd_ack_ok_reg <= ~sda_s;
        end
        else if (scl_fall && state_reg != ST_IDLE)
        begin
            if (bit_reg == twowire_pkg::BIT_ACK)
            begin
                bit_reg <= 4'h0;
                case (state_reg)
                    ST_RDAT:
                    begin
                        // the address acknowledge ends here: send the pointed register
                        if (rd_first_reg)
                            rd_first_reg <= 1'b0;
                        else if (rd_ack_ok_reg)
                        begin
                            ptr_reg <= ptr_reg + 8'h01;
                            tx_reg  <= (ptr_reg + 8'h01 <= twowire_pkg::LAST_REG)
                                     ? regs[4'(ptr_reg + 8'h01)] : twowire_pkg::BEYOND_READ;
                        end
                        else
                            state_reg <= ST_SKIP;
                    end
                    default: ;
                endcase
            end
            else
            begin
                bit_reg <= bit_reg + 4'h1;
                if (bit_reg == twowire_pkg::BIT_LAST)
                begin
                    case (state_reg)
                        ST_ADDR:
                        begin
                            if (shift_reg[7:1] != twowire_pkg::TARGET_ADDR)
                                state_reg <= ST_SKIP;
                            else if (shift_reg[0])
                            begin
                                state_reg <= ST_RDAT;
                                tx_reg    <= rd_value;
                                rd_first_reg <= 1'b1;
                            end
                            else
                                state_reg <= ST_PTR;
                        end
                        ST_PTR:
                        begin
                            ptr_reg   <= shift_reg;
                            state_reg <= ST_WDAT;
                        end
                        ST_WDAT: ptr_reg <= ptr_reg + 8'h01;
                        ST_RDAT: ;
                        default: ;
                    endcase
                end
            end
        end
    end

    // write detection: store happens at the same fall that advances the pointer
    logic wr_strobe;
    assign wr_strobe = scl_fall && state_reg == ST_WDAT && bit_reg == twowire_pkg::BIT_LAST
                       && in_range && !start_ev && !stop_ev;

    always_ff @(posedge CLK)
    begin
        if (RST)
            detect_seen_reg <= 1'b0;
        else if (DETECT_DONE)
            detect_seen_reg <= 1'b1;
        else if (REG_RESET)
            detect_seen_reg <= 1'b0;
    end

    // registers other than the first are plain storage here
    always_ff @(posedge CLK)
    begin
        if (RST || REG_RESET)
        begin
            for (int i = 0; i < twowire_pkg::REG_COUNT; i++)
                regs[i] <= 8'h00;
            regs[0] <= twowire_pkg::POWER_ON_VALUE;
        end
        else
        begin
            if (wr_strobe)
            begin
                if (ptr_reg == twowire_pkg::FIRST_CTRL_OFF && !detect_seen_reg)
                    regs[0][twowire_pkg::DISCONNECT_BIT:twowire_pkg::STATUS_FN_LO]
                        <= shift_reg[7:5];
                else
                    regs[ptr_reg[3:0]] <= shift_reg;
            end
            if (DETECT_DONE)
                regs[0][twowire_pkg::LIMIT_HI:0] <= DETECT_LIMIT;
            if (WATCHDOG_EXPIRED)
                regs[0][twowire_pkg::DISCONNECT_BIT] <= 1'b0;
        end
    end

    // data line driver: set on falling clock so it is steady while high; start and stop also clear it
    logic sda_drive_low;
    always_ff @(posedge CLK)
    begin
        if (RST || start_ev || stop_ev)
            sda_drive_low <= 1'b0;
        else if (scl_fall)
        begin
            if (bit_reg == twowire_pkg::BIT_LAST
                && state_reg inside {ST_PTR, ST_WDAT})
                sda_drive_low <= 1'b1;
            else if (bit_reg == twowire_pkg::BIT_LAST && state_reg == ST_ADDR)
                sda_drive_low <= (shift_reg[7:1] == twowire_pkg::TARGET_ADDR);
            else if (state_reg == ST_RDAT && bit_reg == twowire_pkg::BIT_ACK && rd_first_reg)
                sda_drive_low <= ~tx_reg[3'(twowire_pkg::BIT_LAST)];
            else if (state_reg == ST_RDAT && bit_reg == twowire_pkg::BIT_ACK && rd_ack_ok_reg)
                sda_drive_low <= ~rd_value_next_msb(ptr_reg);
            else if (state_reg == ST_RDAT && bit_reg == twowire_pkg::BIT_LAST)
                sda_drive_low <= 1'b0;                            // release for ack
            else if (state_reg == ST_RDAT && bit_reg < twowire_pkg::BIT_LAST)
                sda_drive_low <= ~tx_reg[3'(twowire_pkg::BIT_LAST - 4'(bit_reg + 4'h1))];
            else
                sda_drive_low <= 1'b0;
        end
    end

    function automatic logic rd_value_next_msb(input logic [7:0] p);
        logic [7:0] n;
        n = p + 8'h01;
        rd_value_next_msb = (n <= twowire_pkg::LAST_REG) ? regs[n[3:0]][7] : 1'b1;
    endfunction : rd_value_next_msb

    assign BUS.sda_oe_n_tgt = ~sda_drive_low;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            INPUT_DISCONNECT_MODE <= 1'b0;
            INPUT_CURRENT_LIMIT   <= twowire_pkg::POWER_ON_VALUE[4:0];
            STATUS_PIN_OE_N       <= 1'b1;
        end
        else
        begin
            INPUT_DISCONNECT_MODE <= regs[0][twowire_pkg::DISCONNECT_BIT];
            INPUT_CURRENT_LIMIT   <= regs[0][twowire_pkg::LIMIT_HI:0];
            case (regs[0][twowire_pkg::STATUS_FN_HI:twowire_pkg::STATUS_FN_LO])
                twowire_pkg::STATUS_FN_CHARGE: STATUS_PIN_OE_N <= ~CHARGING;
                twowire_pkg::STATUS_FN_CUSTOM: STATUS_PIN_OE_N <= ~CUSTOM_STATUS;
                default:                       STATUS_PIN_OE_N <= 1'b1;
            endcase
        end
    end
endmodule : charger_target

// [rtl/host_controller.sv]
// controller end: issues register writes and reads on the two-wire link
// assumes software drives the command port with one-cycle strobes
`timescale 1ns/1ps
module host_controller (
    input  wire logic       CLK,       // system clock
    input  wire logic       RST,       // synchronous reset, high
    twowire_if.controller   BUS,       // two-wire link
    input  wire logic [1:0] ADDR,      // command register address
    input  wire logic [7:0] WDATA,     // write data
    input  wire logic       WR,        // write strobe
    input  wire logic       RD,        // read strobe
    output logic [7:0]      RDATA      // read data, cycle after RD
);
    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_START = 3'b001,
        H_BYTE  = 3'b010,
        H_RSTRT = 3'b011,
        H_STOP  = 3'b100
    } hstate_t;

    logic    sda_s;
    hstate_t state_reg;
    logic [7:0] reg_ptr_reg;
    logic [7:0] data_reg;
    logic [7:0] rx_reg;
    logic [3:0] count_reg;
    logic       read_reg;
    logic       busy_reg;
    logic       nack_reg;
    logic [7:0] half_reg;
    logic [1:0] phase_reg;     // 0 low-a, 1 low-b(change), 2 high, 3 high-end
    logic [3:0] bit_reg;
    logic [2:0] byte_idx_reg;  // 0 addr,1 ptr,2 readdr, 3 write data, 4 read data
    logic [7:0] tx_reg;
    logic       scl_reg;
    logic       sda_reg;

    sync2 u_sync_sda (.CLK(CLK), .RST(RST), .d(BUS.sda_line), .q(sda_s));
    assign BUS.scl_o_n_en_ctl = scl_reg;
    assign BUS.sda_oe_n_ctl   = sda_reg;

    always_ff @(posedge CLK)
    begin
        if (RST)
            RDATA <= 8'h00;
        else if (RD)
            case (ADDR)
                twowire_pkg::CMD_ADDR_REG:    RDATA <= reg_ptr_reg;
                twowire_pkg::CMD_ADDR_DATA:   RDATA <= rx_reg;
                twowire_pkg::CMD_ADDR_STATUS: RDATA <= {6'h00, nack_reg, busy_reg};
                default:                      RDATA <= 8'h00;
            endcase
    end

    logic tick;
    assign tick = (half_reg == twowire_pkg::HALF_CNT);
    always_ff @(posedge CLK)
    begin
        if (RST || state_reg == H_IDLE)
            half_reg <= 8'h00;
        else
            half_reg <= tick ? 8'h00 : half_reg + 8'h01;
    end

    // each bit is four quarter steps: data changes only in the low phase
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state_reg <= H_IDLE; scl_reg <= 1'b1; sda_reg <= 1'b1;
            reg_ptr_reg <= 8'h00; data_reg <= 8'h00; rx_reg <= 8'h00;
            count_reg <= 4'h0; read_reg <= 1'b0; busy_reg <= 1'b0; nack_reg <= 1'b0;
            phase_reg <= 2'h0; bit_reg <= 4'h0; byte_idx_reg <= 3'h0; tx_reg <= 8'h00;
        end
        else if (state_reg == H_IDLE)
        begin
            if (WR && ADDR == twowire_pkg::CMD_ADDR_REG)  reg_ptr_reg <= WDATA;
            if (WR && ADDR == twowire_pkg::CMD_ADDR_DATA) data_reg    <= WDATA;
            if (WR && ADDR == twowire_pkg::CMD_ADDR_GO)
            begin
                read_reg  <= WDATA[twowire_pkg::GO_READ_BIT];
                count_reg <= WDATA[twowire_pkg::GO_COUNT_LO +: 4];
                busy_reg  <= 1'b1; nack_reg <= 1'b0;
                state_reg <= H_START; phase_reg <= 2'h0;
                tx_reg    <= {twowire_pkg::TARGET_ADDR, 1'b0};
                byte_idx_reg <= 3'h0;
            end
        end
        else if (tick)
        begin
            phase_reg <= phase_reg + 2'h1;
            case (state_reg)
                H_START, H_RSTRT:
                    case (phase_reg)
                        2'h0: sda_reg <= 1'b1;
                        2'h1: scl_reg <= 1'b1;
                        2'h2: sda_reg <= 1'b0;
                        default:
                        begin
                            scl_reg <= 1'b0; state_reg <= H_BYTE; bit_reg <= 4'h0;
                        end
                    endcase
                H_BYTE:
                    case (phase_reg)
                        2'h0: ;
                        2'h1:
                        begin
                            if (bit_reg < twowire_pkg::BIT_ACK)
                                sda_reg <= (byte_idx_reg == 3'h4) ? 1'b1 : tx_reg[7];
                            else
                                sda_reg <= (byte_idx_reg == 3'h4) ? (count_reg == 4'h0) : 1'b1;
                        end
                        2'h2: scl_reg <= 1'b1;
                        default:
                        begin
                            scl_reg <= 1'b0;
                            bit_reg <= bit_reg + 4'h1;
                            if (bit_reg < twowire_pkg::BIT_ACK)
                            begin
                                tx_reg <= {tx_reg[6:0], 1'b0};
                                rx_reg <= {rx_reg[6:0], sda_s};
                            end
                            else
                            begin
                                bit_reg <= 4'h0;
                                if (byte_idx_reg != 3'h4 && sda_s)
                                begin
                                    nack_reg <= 1'b1; state_reg <= H_STOP;
                                end
                                else
                                    case (byte_idx_reg)
                                        3'h0: begin byte_idx_reg <= 3'h1; tx_reg <= reg_ptr_reg; end
                                        3'h1:
                                            if (read_reg)
                                            begin
                                                byte_idx_reg <= 3'h2; state_reg <= H_RSTRT;
                                                tx_reg <= {twowire_pkg::TARGET_ADDR, 1'b1};
                                            end
                                            else
                                            begin
                                                byte_idx_reg <= 3'h3; tx_reg <= data_reg;
                                            end
                                        3'h2: byte_idx_reg <= 3'h4;
                                        // an acknowledged read byte is followed by another
                                        3'h4:
                                            if (count_reg != 4'h0)
                                                count_reg <= count_reg - 4'h1;
                                            else
                                                state_reg <= H_STOP;
                                        default: state_reg <= H_STOP;
                                    endcase
                            end
                        end
                    endcase
                H_STOP:
                    case (phase_reg)
                        2'h0: ;
                        2'h1: sda_reg <= 1'b0;
                        2'h2: scl_reg <= 1'b1;
                        default:
                        begin
                            sda_reg <= 1'b1; busy_reg <= 1'b0; state_reg <= H_IDLE;
                        end
                    endcase
                default: state_reg <= H_IDLE;
            endcase
        end
    end
endmodule : host_controller

// [dv/charger_i2c_register_port_monitor.sv]
// checker for the two-wire link between the controller and target ends
// assumes both wires are sampled on the shared system clock
`timescale 1ns/1ps
module charger_i2c_register_port_monitor (
    input  wire logic CLK,          // system clock
    input  wire logic RST,          // synchronous reset, high
    input  wire logic sda_oe_n_ctl, // controller data release
    input  wire logic sda_oe_n_tgt, // target data release
    input  wire logic scl_line,     // clock wire
    input  wire logic sda_line      // data wire
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    logic       scl_prev_reg;
    logic       sda_prev_reg;
    logic [3:0] rises_reg;
    logic       start;
    logic       stop;
    assign start = scl_line && scl_prev_reg && sda_prev_reg && !sda_line;
    assign stop  = scl_line && scl_prev_reg && !sda_prev_reg && sda_line;
    always_ff @(posedge CLK)
    begin
        scl_prev_reg <= scl_line;
        sda_prev_reg <= sda_line;
    end
    // saturates so that only the address byte can reach nine
    always_ff @(posedge CLK)
    begin
        if (RST || start)
            rises_reg <= 4'h0;
        else if (scl_line && !scl_prev_reg && rises_reg != 4'hF)
            rises_reg <= rises_reg + 4'h1;
    end
    tgt_data_stable_a: assert property ($changed(sda_oe_n_tgt) |-> !scl_line)
        else $error("target data moved while clock high");
    clk_high_min_a: assert property ($rose(scl_line) |-> scl_line [*4])
        else $error("clock high phase too short");
    clk_low_min_a: assert property ($fell(scl_line) |-> !scl_line [*4])
        else $error("clock low phase too short");
    clk_low_bound_a: assert property ($fell(scl_line) |-> ##[1:32] scl_line)
        else $error("clock held low too long");
    first_byte_drive_a: assert property (scl_line && scl_prev_reg && !sda_oe_n_tgt
        && rises_reg <= 4'h9 |-> rises_reg == 4'h9) else $error("target drove address bits");
    own_addr_ack_a: assert property (rises_reg == 4'h9 && scl_line && scl_prev_reg
        |-> !sda_oe_n_tgt) else $error("own address not acknowledged");
    start_released_a: assert property (start |-> sda_oe_n_tgt)
        else $error("target held data at start");
    stop_released_a: assert property (stop |-> sda_oe_n_tgt && sda_oe_n_ctl)
        else $error("data not released at stop");
endmodule : charger_i2c_register_port_monitor

// [dv/charger_i2c_register_port_tb.sv]
// self-checking bench: host_controller talks to charger_target over twowire_if
// assumes 100 MHz system clock; the controller derives the link clock itself
`timescale 1ns/1ps
module charger_i2c_register_port_tb;
    logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
    logic       reg_reset = 1'b0, wdog = 1'b0, det_done = 1'b0, charging = 1'b0, custom = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [3:0] acks = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, d;
    logic [4:0] det_limit = 5'h00, limit;
    logic       disc, stat_oe_n, busy;
    logic [8:0] exp_q[$];
    logic [8:0] note;
    int         n_fail = 0, compares = 0, k;
    integer     seed = 32'h677b;
    initial forever #5 clk = ~clk;
    twowire_if u_twowire_if ();
    charger_target u_charger_target (.CLK(clk), .RST(rst), .BUS(u_twowire_if.target),
        .REG_RESET(reg_reset), .WATCHDOG_EXPIRED(wdog), .DETECT_DONE(det_done),
        .DETECT_LIMIT(det_limit), .CHARGING(charging), .CUSTOM_STATUS(custom),
        .INPUT_DISCONNECT_MODE(disc), .INPUT_CURRENT_LIMIT(limit),
        .STATUS_PIN_OE_N(stat_oe_n), .BUS_BUSY(busy));
    host_controller u_host_controller (.CLK(clk), .RST(rst), .BUS(u_twowire_if.controller),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));
    charger_i2c_register_port_monitor u_charger_i2c_register_port_monitor (.CLK(clk),
        .RST(rst), .sda_oe_n_ctl(u_twowire_if.sda_oe_n_ctl),
        .sda_oe_n_tgt(u_twowire_if.sda_oe_n_tgt), .scl_line(u_twowire_if.scl_line),
        .sda_line(u_twowire_if.sda_line));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, want, seen);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic cmd_wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : cmd_wr
    // bit 8 of a note marks a value to compare; poll reads carry none
    task automatic cmd_rd(input logic [1:0] a, input logic [8:0] n);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        exp_q.push_back(n);
        @(posedge clk);
        rd   <= 1'b0;
    endtask : cmd_rd
    always @(posedge clk)
    begin
        rd_d <= rd;
        if (rd_d && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            if (note[8])
                chk("rdata", rdata, note[7:0]);
        end
    end
    task automatic xfer(input logic [7:0] ptr, input logic [7:0] v, input logic rdir);
        int i;
        cmd_wr(2'h0, ptr);
        cmd_wr(2'h1, v);
        cmd_wr(2'h2, {acks, 3'h0, rdir});
        repeat (20) @(posedge clk);
        chk("busy", {7'h00, busy}, 8'h01);
        for (i = 0; i < 2000; i++)
        begin
            cmd_rd(2'h3, 9'h000);
            #1;
            if (rdata[0] === 1'b0)
                break;
        end
        if (i == 2000)
        begin
            n_fail++;
            $display("[ERR] transfer did not finish");
            tally_and_finish();
        end
        repeat (4) @(posedge clk);
        chk("busy", {7'h00, busy}, 8'h00);
        cmd_rd(2'h3, 9'h100);
    endtask : xfer
    task automatic rreg(input logic [7:0] ptr, input logic [7:0] want);
        xfer(ptr, 8'h00, 1'b1);
        cmd_rd(2'h1, {1'b1, want});
    endtask : rreg
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rreg(8'h00, twowire_pkg::POWER_ON_VALUE);
        chk("limit", {3'h0, limit}, 8'h17);
        xfer(8'h00, 8'hFF, 1'b0);
        rreg(8'h00, 8'hF7);
        chk("disc", {7'h00, disc}, 8'h01);
        @(posedge clk);
        det_limit <= 5'($random(seed));
        det_done  <= 1'b1;
        @(posedge clk);
        det_done  <= 1'b0;
        rreg(8'h00, {3'h7, det_limit});
        $display("detection test done");
        for (k = 0; k < 8; k++)
        begin
            charging <= k[2];
            custom   <= ~k[2];
            xfer(8'h00, {1'b0, k[1:0], 5'h1F}, 1'b0);
            chk("stat", {7'h00, stat_oe_n}, {7'h00, !((k[1:0] == 2'h0 && k[2])
                || (k[1:0] == 2'h1 && !k[2]))});
        end
        chk("limit", {3'h0, limit}, 8'h1F);
        $display("status pin test done");
        xfer(8'h00, 8'hFF, 1'b0);
        @(posedge clk);
        wdog      <= 1'b1;
        @(posedge clk);
        wdog      <= 1'b0;
        rreg(8'h00, 8'h7F);
        @(posedge clk);
        reg_reset <= 1'b1;
        @(posedge clk);
        reg_reset <= 1'b0;
        xfer(8'h00, 8'h00, 1'b0);
        rreg(8'h00, 8'h17);
        $display("reset source test done");
        for (k = 1; k < 18; k++)
        begin
            d = (k < 16) ? 8'($random(seed)) : 8'hFF;
            xfer(8'(k), d, 1'b0);
            rreg(8'(k), d);
        end
        acks = 4'h1;
        xfer(8'h0F, 8'h00, 1'b1);
        acks = 4'h0;
        cmd_rd(2'h1, 9'h1FF);
        repeat (2) @(posedge clk);
        $display("register map test done");
        tally_and_finish();
    end
endmodule : charger_i2c_register_port_tb
